// *** core/ptp_position_trigger.sv ***
/*
 * position trigger: arms on software request, fires pulses at start plus multiples of the interval,
 * disarms at the last grid pulse or the stop position; fast pin output and slow general-output pulse.
 * assumes feedbackPos is in control units, already scaled, and steady when posUpdate is high.
 */
// Notes on behaviour
// - arm only with digital encoder, homing done, and arm flag written to one.
// - disarm automatically after the last grid pulse, or once the position reaches the stop position.
// - writing zero to the arm flag disarms at once, no more pulses.
// - pulses continue while armed even with the motor disabled.
// - first pulse fires when the position reaches the start position.
// - later pulses at start plus whole intervals; stop pulse only on grid.
// - positive direction if start below stop, negative if start above stop.
// - fast pulse lasts width setting times 20 ns, 1 to 4095, default 100.
// - slow pulse lasts width setting times 0.25 ms, 1 to 4000, default 1.
// - polarity field zero gives high pulse, one gives low pulse by default.
// - lowest config field enables the function; config applies after power-up.
// - start and stop are signed, default zero, and apply immediately.
// - interval is non-negative, default zero, and applies immediately.
// - fast pulse starts within 10 ns, slow pulse within 0.25 ms.
// - only fixed-interval mode between start and stop exists.
// - scaled start, stop or interval outside signed 31 bits raises the alarm.
`timescale 1ns/10ps
`include "ptp_defines.svh"
module ptp_position_trigger import ptp_pkg::*; #(
    parameter int SLOW_UNIT_CYC = `PTP_SLOW_UNIT_CYC,
    parameter int SW_TICK_CYC = `PTP_SW_TICK_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic restartLoad,
    input wire ptp_wr_s paramWr,
    input wire logic rdEn,
    input wire logic [2:0] rdSel,
    output logic [31:0] rdData,
    output logic rdValid,
    input wire logic digitalEncoder,
    input wire logic homingDone,
    input wire ptp_pos_t feedbackPos,
    input wire logic posUpdate,
    input wire logic [31:0] gearNumerator,
    input wire logic [31:0] gearDenominator,
    output logic posTriggerOut,
    output logic generalOutTrigger,
    output logic paramRangeAlarm,
    output ptp_status_s status
);
    localparam int TW = $clog2(SW_TICK_CYC + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(SW_TICK_CYC - 1);

    ptp_state_e state_q;
    logic [15:0] cfgPend_q;
    logic [15:0] cfgAct_q;
    logic [11:0] fastWPend_q;
    logic [11:0] fastWAct_q;
    logic [11:0] slowWPend_q;
    logic [11:0] slowWAct_q;
    ptp_pos_t start_q;
    ptp_pos_t interval_q;
    ptp_pos_t stop_q;
    ptp_pos_t target_q;
    logic dirPos_q;
    logic alarm_q;
    logic swPend_q;
    logic [TW-1:0] tick_q;
    logic swTick;
    logic wrSel;
    logic [11:0] wrWidth;
    logic wrArm1;
    logic wrArm0;
    logic cfgEnable;
    logic cfgLowActive;
    logic canArm;
    logic armed;
    logic hit;
    logic pastStop;
    logic lastHit;
    logic fire;
    logic [32:0] nextWide;
    ptp_pos_t nextTarget;
    logic badStart;
    logic badInterval;
    logic badStop;
    logic fastBusy;
    logic slowBusy;

    // decode of the software write
    assign wrWidth = paramWr.data[11:0];
    assign wrArm1 = paramWr.en && (paramWr.sel == `PTP_SEL_ARM) && paramWr.data[0];
    assign wrArm0 = paramWr.en && (paramWr.sel == `PTP_SEL_ARM) && !paramWr.data[0];
    assign wrSel = paramWr.en;

    // fields of the active config copy
    assign cfgEnable = (cfgAct_q[`PTP_CFG_EN_LSB +: 4] == `PTP_CFG_DIGIT_ON);
    assign cfgLowActive = (cfgAct_q[`PTP_CFG_POL_LSB +: 4] == `PTP_CFG_DIGIT_ON);

    // stored settings; active copies reload only at power-up or restart
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfgPend_q <= `PTP_CFG_RESET;
            fastWPend_q <= `PTP_FAST_W_RESET;
            slowWPend_q <= `PTP_SLOW_W_RESET;
        end else if (wrSel) begin
            if (paramWr.sel == `PTP_SEL_CONFIG) begin
                cfgPend_q <= paramWr.data[15:0];
            end
            // out-of-range widths are refused, the old value stays
            if ((paramWr.sel == `PTP_SEL_FAST_W) && (wrWidth >= `PTP_W_MIN) && (paramWr.data[15:12] == 4'h0)) begin
                fastWPend_q <= wrWidth;
            end
            if ((paramWr.sel == `PTP_SEL_SLOW_W) && (wrWidth >= `PTP_W_MIN) && (wrWidth <= `PTP_SLOW_W_MAX)
                && (paramWr.data[15:12] == 4'h0)) begin
                slowWPend_q <= wrWidth;
            end
        end
    end

    // after-power-up copies
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfgAct_q <= `PTP_CFG_RESET;
            fastWAct_q <= `PTP_FAST_W_RESET;
            slowWAct_q <= `PTP_SLOW_W_RESET;
        end else if (restartLoad) begin
            cfgAct_q <= cfgPend_q;
            fastWAct_q <= fastWPend_q;
            slowWAct_q <= slowWPend_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            start_q <= `PTP_POS_RESET;
            interval_q <= `PTP_POS_RESET;
            stop_q <= `PTP_POS_RESET;
        end else if (wrSel) begin
            if (paramWr.sel == `PTP_SEL_START) begin
                start_q <= paramWr.data;
            end
            if (paramWr.sel == `PTP_SEL_INTERVAL) begin
                interval_q <= paramWr.data;
            end
            if (paramWr.sel == `PTP_SEL_STOP) begin
                stop_q <= paramWr.data;
            end
        end
    end

    ptp_range_check #(.ALLOW_NEG(1'b1)) u_chkStart (
        .setting(start_q),
        .gearNum(gearNumerator),
        .gearDen(gearDenominator),
        .bad(badStart)
    );
    ptp_range_check #(.ALLOW_NEG(1'b0)) u_chkInterval (
        .setting(interval_q),
        .gearNum(gearNumerator),
        .gearDen(gearDenominator),
        .bad(badInterval)
    );
    ptp_range_check #(.ALLOW_NEG(1'b1)) u_chkStop (
        .setting(stop_q),
        .gearNum(gearNumerator),
        .gearDen(gearDenominator),
        .bad(badStop)
    );

    // alarm follows the settings, one cycle behind
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            alarm_q <= 1'b0;
        end else begin
            alarm_q <= badStart || badInterval || badStop;
        end
    end

    assign armed = (state_q == PTP_ARMED);
    assign hit = dirPos_q ? (feedbackPos >= target_q) : (feedbackPos <= target_q);
    assign pastStop = dirPos_q ? (feedbackPos >= stop_q) : (feedbackPos <= stop_q);
    assign nextWide = dirPos_q ? (33'(target_q) + 33'(interval_q)) : (33'(target_q) - 33'(interval_q));
    assign nextTarget = nextWide[31:0];
    // grid end: a zero interval gives one pulse, the stop pulse only on the grid
    assign lastHit = (interval_q == 32'h0) || (target_q == stop_q)
        || (dirPos_q ? ($signed(nextWide) > 33'(stop_q)) : ($signed(nextWide) < 33'(stop_q)));
    // a disarm write in the same cycle suppresses the pulse
    assign fire = armed && posUpdate && hit && !wrArm0;
    // all arming conditions together; a range alarm also blocks arming
    assign canArm = digitalEncoder && homingDone && cfgEnable && !alarm_q;

    // arming state; motor enable is deliberately not an input
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_q <= PTP_IDLE;
        end else begin
            unique case (state_q)
                PTP_IDLE: begin
                    if (wrArm1 && canArm) begin
                        state_q <= PTP_ARMED;
                    end
                end
                PTP_ARMED: begin
                    if (wrArm0) begin
                        state_q <= PTP_IDLE;
                    end else if (posUpdate && ((hit && lastHit) || (!hit && pastStop))) begin
                        state_q <= PTP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            target_q <= `PTP_POS_RESET;
            dirPos_q <= 1'b1;
        end else if (!armed && wrArm1 && canArm) begin
            target_q <= start_q;
            dirPos_q <= (start_q <= stop_q);
        end else if (fire && !lastHit) begin
            target_q <= nextTarget;
        end
    end

    // fast path fires the cycle after the compare
    ptp_pulse_gen #(.UNIT_CYC(`PTP_FAST_UNIT_CYC), .WW(12)) u_fastPulse (
        .core_clk(core_clk),
        .rstn(rstn),
        .trig(fire),
        .width(fastWAct_q),
        .lowActive(cfgLowActive),
        .pulseOut(posTriggerOut),
        .busy(fastBusy)
    );

    // software-rate tick; the slow path only acts on it
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tick_q <= TICK_LAST;
        end else begin
            tick_q <= (tick_q == '0) ? TICK_LAST : tick_q - TW'(1);
        end
    end
    assign swTick = (tick_q == '0);

    // pending slow event; a new fire wins over the clear
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            swPend_q <= 1'b0;
        end else begin
            swPend_q <= fire || (swPend_q && !swTick);
        end
    end

    // slow path, a slow pulse still running swallows the event
    ptp_pulse_gen #(.UNIT_CYC(SLOW_UNIT_CYC), .WW(12)) u_slowPulse (
        .core_clk(core_clk),
        .rstn(rstn),
        .trig(swTick && swPend_q),
        .width(slowWAct_q),
        .lowActive(cfgLowActive),
        .pulseOut(generalOutTrigger),
        .busy(slowBusy)
    );

    // readback, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdData <= 32'h0;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdEn;
            if (rdEn) begin
                unique case (rdSel)
                    `PTP_SEL_CONFIG: rdData <= {16'h0, cfgPend_q};
                    `PTP_SEL_START: rdData <= start_q;
                    `PTP_SEL_INTERVAL: rdData <= interval_q;
                    `PTP_SEL_STOP: rdData <= stop_q;
                    `PTP_SEL_FAST_W: rdData <= {20'h0, fastWPend_q};
                    `PTP_SEL_SLOW_W: rdData <= {20'h0, slowWPend_q};
                    `PTP_SEL_ARM: rdData <= {31'h0, armed};
                    `PTP_SEL_STATUS: rdData <= {26'h0, fastBusy, slowBusy, swPend_q, dirPos_q, alarm_q, armed};
                endcase
            end
        end
    end

    assign paramRangeAlarm = alarm_q;
    assign status = '{armed: armed, alarm: alarm_q, dirPositive: dirPos_q, swPending: swPend_q};

    // checks on the comparator and arming
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_arm_request;
        wrArm1 && !armed;
    endsequence

    sequence s_disarm_request;
        wrArm0 ##1 1'b1;
    endsequence

    a_arm_needs_all: assert property (
        $rose(armed) |-> $past(wrArm1 && digitalEncoder && homingDone && cfgEnable))
        else $error("armed without all arming conditions");

    // no rearm without a fresh write
    a_no_self_rearm: assert property (
        (!armed && !wrArm1) |=> !armed)
        else $error("armed without a write of one");

    a_stop_disarms: assert property (
        (armed && posUpdate && !hit && pastStop && !wrArm0) |=> !armed && !fire)
        else $error("not disarmed at the stop position");

    a_clear_disarms: assert property (
        (armed and s_disarm_request) |-> $past(!fire) ##0 (!armed [*2]))
        else $error("pulse or armed state after disarm write");

    a_arm_loads: assert property (
        (s_arm_request ##1 armed) |-> (target_q == $past(start_q)) && (dirPos_q == ($past(start_q) <= $past(stop_q))))
        else $error("first target or direction wrong at arming");

    // step by one interval toward stop
    a_target_step: assert property (
        (fire && !lastHit) |=> (armed && (target_q == ($past(dirPos_q) ? $past(target_q) + $past(interval_q)
            : $past(target_q) - $past(interval_q)))))
        else $error("target not advanced by one interval");

    // fast pulse shows within one clock; a fire into a running pulse is dropped
    a_fast_delay: assert property (
        (fire && !fastBusy) |=> (fastBusy && (posTriggerOut == !cfgLowActive)))
        else $error("fast pulse not out within 10 ns");

    // slow pulse begins before the next software tick passes
    a_slow_delay: assert property (
        (swPend_q && swTick && !slowBusy) |=> slowBusy)
        else $error("slow pulse not started at the tick");

    a_alarm_tracks: assert property (
        (badStart || badInterval || badStop) |=> alarm_q)
        else $error("range alarm missing for bad setting");

endmodule // ptp_position_trigger

// *** core/ptp_defines.svh ***
/*
 * selector codes, field positions, reset values and timing counts for the position trigger.
 * assumes a 100 MHz core clock; included by bare name from core/.
 */
`ifndef PTP_DEFINES_SVH
`define PTP_DEFINES_SVH

// parameter selector codes on the write and read ports
`define PTP_SEL_CONFIG 3'h0
`define PTP_SEL_START 3'h1
`define PTP_SEL_INTERVAL 3'h2
`define PTP_SEL_STOP 3'h3
`define PTP_SEL_FAST_W 3'h4
`define PTP_SEL_SLOW_W 3'h5
`define PTP_SEL_ARM 3'h6
`define PTP_SEL_STATUS 3'h7

// trigger_config digit fields
`define PTP_CFG_EN_LSB 0
`define PTP_CFG_POL_LSB 8
`define PTP_CFG_DIGIT_ON 4'h1

// reset values
`define PTP_CFG_RESET 16'h0111
`define PTP_FAST_W_RESET 12'h064
`define PTP_SLOW_W_RESET 12'h001
`define PTP_POS_RESET 32'h00000000

// legal width settings
`define PTP_W_MIN 12'h001
`define PTP_FAST_W_MAX 12'hfff
`define PTP_SLOW_W_MAX 12'hfa0

// timing: figures in their own units, counts derived from the clock
`define PTP_CLK_MHZ 100
`define PTP_FAST_UNIT_NS 20
`define PTP_FAST_UNIT_CYC ((`PTP_FAST_UNIT_NS * `PTP_CLK_MHZ + 999) / 1000)
`define PTP_SLOW_UNIT_US 250
`define PTP_SLOW_UNIT_CYC (`PTP_SLOW_UNIT_US * `PTP_CLK_MHZ)
`define PTP_SW_UPDATE_HZ 16000
`define PTP_SW_TICK_CYC ((`PTP_CLK_MHZ * 1000000) / `PTP_SW_UPDATE_HZ)
`define PTP_HW_DELAY_NS 10
`define PTP_HW_DELAY_CYC ((`PTP_HW_DELAY_NS * `PTP_CLK_MHZ) / 1000)

`endif

// *** core/ptp_pkg.sv ***
/*
 * types shared by the position trigger modules.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package ptp_pkg;

    // arming state of the comparator
    typedef enum logic [0:0] {PTP_IDLE, PTP_ARMED} ptp_state_e;

    // one parameter write from the controlling software
    typedef struct packed {
        logic en;
        logic [2:0] sel;
        logic [31:0] data;
    } ptp_wr_s;

    // state shown to the outside
    typedef struct packed {
        logic armed;
        logic alarm;
        logic dirPositive;
        logic swPending;
    } ptp_status_s;

    typedef logic signed [31:0] ptp_pos_t;

endpackage

// *** core/ptp_pulse_gen.sv ***
/*
 * retriggerable-when-idle pulse stretcher: width setting times UNIT_CYC clock cycles.
 * assumes trig is a one-cycle pulse and width is held steady by the caller.
 */
`timescale 1ns/10ps
module ptp_pulse_gen import ptp_pkg::*; #(
    parameter int UNIT_CYC = 2,
    parameter int WW = 12
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic trig,
    input wire logic [WW-1:0] width,
    input wire logic lowActive,
    output logic pulseOut,
    output logic busy
);
    localparam int PW = $clog2(UNIT_CYC + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYC - 1);

    logic [WW-1:0] units_q;
    logic [PW-1:0] pre_q;
    logic start;
    logic activeNext;
    logic [WW-1:0] len_q;
    logic [27:0] cnt_q;

    // a trigger that lands during a pulse is dropped, never stretches it
    assign start = trig && (units_q == '0) && (width != '0);
    assign busy = (units_q != '0);
    assign activeNext = start || (busy && !((pre_q == '0) && (units_q == WW'(1))));

    // unit prescaler and unit count
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            units_q <= '0;
            pre_q <= '0;
        end else if (start) begin
            units_q <= width;
            pre_q <= PRE_LAST;
        end else if (busy) begin
            if (pre_q == '0) begin
                units_q <= units_q - WW'(1);
                pre_q <= PRE_LAST;
            end else begin
                pre_q <= pre_q - PW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pulseOut <= 1'b1; // default is low-active, so idle high
        end else begin
            pulseOut <= activeNext ? ~lowActive : lowActive;
        end
    end

    // helper: length of the pulse now running
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            len_q <= '0;
            cnt_q <= '0;
        end else begin
            if (start) begin
                len_q <= width;
            end
            cnt_q <= busy ? cnt_q + 28'h1 : 28'h0;
        end
    end

    a_pulse_length: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(busy) |-> (cnt_q == 28'(len_q * UNIT_CYC)))
        else $error("pulse length differs from width times unit");

    a_idle_level: assert property (@(posedge core_clk) disable iff (!rstn)
        (!busy && !$past(start)) |-> (pulseOut == $past(lowActive)))
        else $error("idle output level wrong for polarity");

endmodule // ptp_pulse_gen

// *** core/ptp_range_check.sv ***
/*
 * checks that a setting scaled by numerator over denominator stays within the signed 31-bit span.
 * assumes purely combinational use; the caller registers the result.
 */
`timescale 1ns/10ps
module ptp_range_check import ptp_pkg::*; #(
    parameter bit ALLOW_NEG = 1'b1
) (
    input wire ptp_pos_t setting,
    input wire logic [31:0] gearNum,
    input wire logic [31:0] gearDen,
    output logic bad
);
    localparam logic [63:0] SPAN = 64'h000000007fffffff;

    logic [31:0] mag;
    logic [63:0] lhs;
    logic [63:0] rhs;

    // compare by cross multiplication, avoiding a divider
    assign mag = setting[31] ? 32'(-setting) : setting;
    assign lhs = 64'(mag) * 64'(gearNum);
    assign rhs = 64'(SPAN * 64'(gearDen));
    assign bad = (gearDen == 32'h0) || (lhs > rhs) || (!ALLOW_NEG && setting[31]);

endmodule // ptp_range_check

// *** test/ptp_trig_sink.sv ***
/*
 * triggered-equipment model: counts trigger pulses and measures the width of the last one.
 * assumes trigIn is synchronous to core_clk and lowActive gives the active level.
 */
`timescale 1ns/10ps
module ptp_trig_sink (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic trigIn,
    input wire logic lowActive,
    output logic [15:0] pulseCount,
    output logic [15:0] lastWidth
);
    logic [15:0] runQ;
    logic wasActiveQ;
    wire logic active = trigIn ^ lowActive;

    // edge counting and width capture; width is in whole clock cycles
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pulseCount <= 16'h0;
            lastWidth <= 16'h0;
            runQ <= 16'h0;
            wasActiveQ <= 1'b0;
        end else begin
            wasActiveQ <= active;
            runQ <= active ? runQ + 16'h1 : 16'h0;
            if (active && !wasActiveQ) pulseCount <= pulseCount + 16'h1;
            if (!active && wasActiveQ) lastWidth <= runQ;
        end
    end
endmodule // ptp_trig_sink

// *** test/tb.sv ***
/*
 * self-checking bench for the position trigger, with small slow-unit and tick counts.
 * assumes the design sources in core/ and the sink model in test/.
 */
`timescale 1ns/10ps
`include "ptp_defines.svh"
module tb;
    import ptp_pkg::*;
    logic core_clk = 1'b0, rstn = 1'b0, restartLoad = 1'b0, rdEn = 1'b0, posUpdate = 1'b0;
    logic digitalEncoder = 1'b1, homingDone = 1'b0, lowAct = 1'b1;
    logic [2:0] rdSel = 3'h0;
    logic [31:0] gearNum = 32'h1, gearDen = 32'h1, rdData;
    ptp_wr_s paramWr = '0;
    ptp_pos_t feedbackPos = 32'sh0;
    logic rdValid, posTriggerOut, generalOutTrigger, paramRangeAlarm;
    ptp_status_s status;
    logic [15:0] fastCnt, fastW, slowCnt, slowW, fBase, sBase;
    int mismatches = 0, tests_run = 0, cycles = 0;

    ptp_position_trigger #(.SLOW_UNIT_CYC(4), .SW_TICK_CYC(8)) u_ptp_position_trigger (
        .core_clk(core_clk), .rstn(rstn), .restartLoad(restartLoad), .paramWr(paramWr), .rdEn(rdEn),
        .rdSel(rdSel), .rdData(rdData), .rdValid(rdValid), .digitalEncoder(digitalEncoder),
        .homingDone(homingDone), .feedbackPos(feedbackPos), .posUpdate(posUpdate), .gearNumerator(gearNum),
        .gearDenominator(gearDen), .posTriggerOut(posTriggerOut), .generalOutTrigger(generalOutTrigger),
        .paramRangeAlarm(paramRangeAlarm), .status(status));
    ptp_trig_sink u_fast (.core_clk(core_clk), .rstn(rstn), .trigIn(posTriggerOut), .lowActive(lowAct),
        .pulseCount(fastCnt), .lastWidth(fastW));
    ptp_trig_sink u_slow (.core_clk(core_clk), .rstn(rstn), .trigIn(generalOutTrigger), .lowActive(lowAct),
        .pulseCount(slowCnt), .lastWidth(slowW));

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // hang guard; a run of about 530 cycles is expected
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [2:0] sel, input logic [31:0] data);
        @(negedge core_clk);
        paramWr = '{en: 1'b1, sel: sel, data: data};
        @(negedge core_clk);
        paramWr.en = 1'b0;
    endtask

    // read answers one cycle after the request edge
    task automatic rd(input logic [2:0] sel, input logic [31:0] mask, input logic [31:0] exp);
        @(negedge core_clk);
        rdEn = 1'b1;
        rdSel = sel;
        @(negedge core_clk);
        rdEn = 1'b0;
        check({31'h0, rdValid}, 32'h1);
        check(rdData & mask, exp);
    endtask

    // reload of stored config and widths
    task automatic reload();
        @(negedge core_clk);
        restartLoad = 1'b1;
        @(negedge core_clk);
        restartLoad = 1'b0;
    endtask

    // one position update; fast pin level checked one cycle later
    task automatic move(input int pos, input logic fire);
        @(negedge core_clk);
        feedbackPos = pos;
        posUpdate = 1'b1;
        @(negedge core_clk);
        posUpdate = 1'b0;
        check({31'h0, posTriggerOut}, {31'h0, fire ^ lowAct});
        // updates spaced so each slow pulse ends before the next update
        repeat (18) @(negedge core_clk);
    endtask

    task automatic arm_seq(input int st, input int iv, input int sp);
        wr(`PTP_SEL_START, st);
        wr(`PTP_SEL_INTERVAL, iv);
        wr(`PTP_SEL_STOP, sp);
        wr(`PTP_SEL_ARM, 32'h1);
        fBase = fastCnt;
        sBase = slowCnt;
    endtask

    task automatic expect_end(input logic [15:0] n);
        check({16'h0, fastCnt - fBase}, {16'h0, n});
        check({16'h0, slowCnt - sBase}, {16'h0, n});
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h0);
    endtask

    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        // stored values after reset
        rd(`PTP_SEL_CONFIG, 32'hffffffff, 32'h111);
        rd(`PTP_SEL_START, 32'hffffffff, 32'h0);
        rd(`PTP_SEL_INTERVAL, 32'hffffffff, 32'h0);
        rd(`PTP_SEL_STOP, 32'hffffffff, 32'h0);
        rd(`PTP_SEL_FAST_W, 32'hffffffff, 32'd100);
        rd(`PTP_SEL_SLOW_W, 32'hffffffff, 32'h1);
        // out-of-range widths are ignored
        wr(`PTP_SEL_FAST_W, 32'h0);
        wr(`PTP_SEL_FAST_W, 32'h1000);
        wr(`PTP_SEL_SLOW_W, 32'd4001);
        rd(`PTP_SEL_FAST_W, 32'hffffffff, 32'd100);
        rd(`PTP_SEL_SLOW_W, 32'hffffffff, 32'h1);
        wr(`PTP_SEL_FAST_W, 32'h1);
        wr(`PTP_SEL_SLOW_W, 32'h2);
        reload();
        // arming needs all conditions together
        wr(`PTP_SEL_ARM, 32'h1);
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h0);
        homingDone = 1'b1;
        digitalEncoder = 1'b0;
        wr(`PTP_SEL_ARM, 32'h1);
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h0);
        digitalEncoder = 1'b1;
        // zero gear denominator is out of range and blocks arming
        gearDen = 32'h0;
        repeat (3) @(negedge core_clk);
        check({31'h0, paramRangeAlarm}, 32'h1);
        wr(`PTP_SEL_ARM, 32'h1);
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h0);
        gearDen = 32'h1;
        repeat (3) @(negedge core_clk);
        check({31'h0, paramRangeAlarm}, 32'h0);
        // positive run, stop on the grid
        arm_seq(10, 5, 20);
        rd(`PTP_SEL_STATUS, 32'h7, 32'h5);
        check({28'h0, status}, 32'ha);
        move(8, 1'b0);
        move(10, 1'b1);
        move(16, 1'b1);
        move(20, 1'b1);
        expect_end(16'h3);
        check({16'h0, fastW}, 32'h2);
        check({16'h0, slowW}, 32'h8);
        move(25, 1'b0);
        // stop off the grid
        arm_seq(0, 7, 20);
        move(0, 1'b1);
        move(7, 1'b1);
        move(14, 1'b1);
        move(18, 1'b0);
        expect_end(16'h3);
        // negative run
        arm_seq(20, 5, 10);
        rd(`PTP_SEL_STATUS, 32'h7, 32'h1);
        move(21, 1'b0);
        move(20, 1'b1);
        move(15, 1'b1);
        move(10, 1'b1);
        expect_end(16'h3);
        // software disarm, then rearm restarts from start
        arm_seq(0, 5, 100);
        move(0, 1'b1);
        wr(`PTP_SEL_ARM, 32'h0);
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h0);
        move(5, 1'b0);
        move(10, 1'b0);
        wr(`PTP_SEL_ARM, 32'h1);
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h1);
        move(10, 1'b1);
        // stop moved behind the axis: disarm with no pulse
        wr(`PTP_SEL_STOP, 32'd3);
        move(4, 1'b0);
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h0);
        wr(`PTP_SEL_ARM, 32'h0);
        // high-level pulse after reload; polarity tracked in the sinks
        wr(`PTP_SEL_CONFIG, 32'h11);
        reload();
        lowAct = 1'b0;
        rd(`PTP_SEL_CONFIG, 32'hffffffff, 32'h11);
        arm_seq(0, 5, 5);
        move(0, 1'b1);
        move(5, 1'b1);
        expect_end(16'h2);
        // enable digit zero stops arming
        wr(`PTP_SEL_CONFIG, 32'h10);
        reload();
        wr(`PTP_SEL_ARM, 32'h1);
        rd(`PTP_SEL_ARM, 32'hffffffff, 32'h0);
        give_verdict();
    end
endmodule // tb
